// ==== hw/ecs_glitch_filter.sv ====
// per-bit two-flop synchroniser followed by a stability filter
// assumes inputs are asynchronous to i_clk
`timescale 1ns/1ps
module ecs_glitch_filter #(
   parameter int W    = 5,
   parameter int FILT = ecs_pkg::SPIKE_CYC
) (
   input  wire logic         i_clk,     // system clock
   input  wire logic         i_rst_n,   // synced reset, active low
   input  wire logic [W-1:0] i_raw,     // raw pin levels
   output logic      [W-1:0] o_clean    // filtered levels
);
   localparam int CW = $clog2(FILT + 2);
   localparam logic [CW-1:0] CNT_MAX  = CW'(FILT);
   localparam logic [CW-1:0] CNT_ZERO = '0;
   localparam logic [CW-1:0] CNT_ONE  = CW'(1);

   // ----------------------------------------------------------------
   // per-bit filter
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic          meta_q, sync_q, out_q, out_d;
         logic [CW-1:0] cnt_q, cnt_d;

         // pulse must outlast the spike window to be taken
         always_comb begin
            out_d = out_q;
            cnt_d = CNT_ZERO;
            if (sync_q != out_q) begin
               if (cnt_q == CNT_MAX) begin
                  out_d = sync_q;                     // [R11]
               end else begin
                  cnt_d = cnt_q + CNT_ONE;
               end
            end
         end

         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               meta_q <= 1'b1;
               sync_q <= 1'b1;
               out_q  <= 1'b1;
               cnt_q  <= '0;
            end else begin
               meta_q <= i_raw[g];
               sync_q <= meta_q;
               out_q  <= out_d;
               cnt_q  <= cnt_d;
            end
         end

         assign o_clean[g] = out_q;
      end
   endgenerate

endmodule : ecs_glitch_filter

// ==== hw/ecs_link_switch.sv ====
// link-clock side: channel enable word and open-drain pass-through
// assumes enable word is stable while its request toggle is pending
`timescale 1ns/1ps
module ecs_link_switch #(
   parameter int N = ecs_pkg::NUM_CHAN
) (
   input  wire logic         i_link_clk,  // link clock
   input  wire logic         i_rst_n,     // raw reset, active low
   input  wire logic         i_req_tgl,   // new enable word toggle
   input  wire logic [N-1:0] i_en_word,   // enable word, held stable
   output logic              o_ack_tgl,   // acknowledge toggle
   input  wire logic         i_up_scl,    // upstream clock level
   input  wire logic         i_up_sda,    // upstream data level
   input  wire logic [N-1:0] i_dn_scl,    // downstream clock levels
   input  wire logic [N-1:0] i_dn_sda,    // downstream data levels
   output logic      [N-1:0] o_dn_scl_oe, // pull downstream clock low
   output logic      [N-1:0] o_dn_sda_oe, // pull downstream data low
   output logic              o_up_scl_pl, // pull upstream clock low
   output logic              o_up_sda_pl, // pull upstream data low
   output logic      [N-1:0] o_chan_en    // active channel enables
);
   // ----------------------------------------------------------------
   // reset and request synchronisers
   // ----------------------------------------------------------------
   logic rst_meta_q, rst_n_q;
   logic req_meta_q, req_s_q, req_prev_q;
   logic [N-1:0] en_q, en_d;

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   always_comb begin
      en_d = en_q;
      if (req_s_q != req_prev_q) begin
         en_d = i_en_word;
      end
   end

   always_ff @(posedge i_link_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         req_meta_q <= 1'b0;
         req_s_q    <= 1'b0;
         req_prev_q <= 1'b0;
         en_q       <= '0;                           // [R6]
      end else begin
         req_meta_q <= i_req_tgl;
         req_s_q    <= req_meta_q;
         req_prev_q <= req_s_q;
         en_q       <= en_d;
      end
   end

   assign o_ack_tgl = req_prev_q;
   assign o_chan_en = en_q;

   // ----------------------------------------------------------------
   // pass-through, echo of own pull masked for the loop delay
   // ----------------------------------------------------------------
   localparam int LW = 2 * N + 2;
   logic [LW-1:0] pin_meta_q, pin_s_q;
   logic [LW-1:0] oe_q, oe_d, oe_h1_q, oe_h2_q, oe_h3_q, busy_mask;

   assign busy_mask = oe_q | oe_h1_q | oe_h2_q | oe_h3_q;

   always_comb begin
      logic [N-1:0] dn_scl_low, dn_sda_low;
      dn_scl_low = en_q & ~pin_s_q[N-1:0] & ~busy_mask[N-1:0];
      dn_sda_low = en_q & ~pin_s_q[2*N-1:N] & ~busy_mask[2*N-1:N];
      oe_d = '0;
      // only enabled channels are joined to the upstream pair
      oe_d[N-1:0]   = en_q & {N{~pin_s_q[2*N]   & ~busy_mask[2*N]}};     // [R1] [R2]
      oe_d[2*N-1:N] = en_q & {N{~pin_s_q[2*N+1] & ~busy_mask[2*N+1]}};   // [R1] [R2]
      oe_d[2*N]     = |dn_scl_low;                                      // [R1]
      oe_d[2*N+1]   = |dn_sda_low;                                      // [R1]
   end

   always_ff @(posedge i_link_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_meta_q <= '1;
         pin_s_q    <= '1;
         oe_q       <= '0;
         oe_h1_q    <= '0;
         oe_h2_q    <= '0;
         oe_h3_q    <= '0;
      end else begin
         pin_meta_q <= {i_up_sda, i_up_scl, i_dn_sda, i_dn_scl};
         pin_s_q    <= pin_meta_q;
         oe_q       <= oe_d;
         oe_h1_q    <= oe_q;
         oe_h2_q    <= oe_h1_q;
         oe_h3_q    <= oe_h2_q;
      end
   end

   assign o_dn_scl_oe = oe_q[N-1:0];
   assign o_dn_sda_oe = oe_q[2*N-1:N];
   assign o_up_scl_pl = oe_q[2*N];
   assign o_up_sda_pl = oe_q[2*N+1];

endmodule : ecs_link_switch

// ==== hw/ecs_pkg.sv ====
// constants and types of the eight-channel two-wire switch control
// assumes a 100 MHz system clock; link side runs on its own clock
package ecs_pkg;
   // ----------------------------------------------------------------
   // clocking and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ      = 100;
   localparam int SPIKE_NS     = 50;
   localparam int SPIKE_CYC    = (SPIKE_NS * CLK_MHZ) / 1000;
   localparam int HOLD_NS      = 300;
   localparam int HOLD_CYC     = (HOLD_NS * CLK_MHZ + 999) / 1000;

   // ----------------------------------------------------------------
   // addressing and framing
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_HI     = 4'hE;
   localparam logic [3:0] BYTE_BITS   = 4'h8;
   localparam logic [3:0] LAST_BIT    = 4'h7;
   localparam logic [3:0] BIT_ONE     = 4'h1;
   localparam logic [3:0] BIT_ZERO    = 4'h0;
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam int         NUM_CHAN    = 8;
   localparam int         HOLD_W      = 6;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE     = 7'h01,
      ST_ADDR     = 7'h02,
      ST_ADDR_ACK = 7'h04,
      ST_WR_DATA  = 7'h08,
      ST_WR_ACK   = 7'h10,
      ST_RD_DATA  = 7'h20,
      ST_RD_ACK   = 7'h40
   } ecs_state_type;
   typedef struct packed {
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } ecs_evt_type;

   typedef struct packed {
      logic [2:0] addr;
      logic       sda;
      logic       scl;
   } ecs_pins_type;
endpackage : ecs_pkg

// ==== hw/ecs_switch_top.sv ====
// top of the eight-channel two-wire switch control
// assumes open-drain pins resolved outside; link clock runs free
//
// Overview of operation
// R1 - upstream pair is joined only to downstream channels whose enable is set
// R2 - any one or any combination of the eight channels may be enabled
// R3 - after address ack master writes or reads one 8-bit control value
// R4 - low slave address bits come from the hardware address pins
// R5 - reset input returns the serial state machine to idle
// R6 - external and power-on reset clear every channel enable
// R7 - external controller holds reset low at least 6 ns
// R8 - master may start immediately after reset release
// R9 - on reset the upstream data line is released within 500 ns
// R10 - master clocks the bus at no more than 400 kHz
// R11 - glitches up to 50 ns on clock and data are ignored
// R12 - data output is held at least 300 ns after clock fall
// R13 - device answers slave addresses 0x70 to 0x77
// R14 - last address bit high means read, low means write
// R15 - bit n selects channel n; written value applies after stop, last byte kept
// R16 - a read returns the control value currently held
`timescale 1ns/1ps
module ecs_switch_top (
   input  wire logic       I_SYS_CLK,                   // system clock
   input  wire logic       I_RST_N,                     // reset, active low
   input  wire logic       I_LINK_CLK,                  // link clock
   input  wire logic       I_SCL_I,                     // upstream clock level
   output logic            O_SCL_O,                     // upstream clock out, 0
   output logic            O_SCL_OE,                    // upstream clock pull
   input  wire logic       I_SDA_I,                     // upstream data level
   output logic            O_SDA_O,                     // upstream data out, 0
   output logic            O_SDA_OE,                    // upstream data pull
   input  wire logic       I_ADDR_PIN_BIT0,             // address pin bit 0
   input  wire logic       I_ADDR_PIN_BIT1,             // address pin bit 1
   input  wire logic       I_ADDR_PIN_BIT2,             // address pin bit 2
   input  wire logic [7:0] I_DOWNSTREAM_CLOCK_LINE_I,   // downstream clock levels
   output logic      [7:0] O_DOWNSTREAM_CLOCK_LINE_O,   // downstream clock out, 0
   output logic      [7:0] O_DOWNSTREAM_CLOCK_LINE_OE,  // downstream clock pulls
   input  wire logic [7:0] I_DOWNSTREAM_DATA_LINE_I,    // downstream data levels
   output logic      [7:0] O_DOWNSTREAM_DATA_LINE_O,    // downstream data out, 0
   output logic      [7:0] O_DOWNSTREAM_DATA_LINE_OE,   // downstream data pulls
   output logic      [7:0] O_CHAN_EN                    // active channel enables
);
   localparam logic [ecs_pkg::HOLD_W-1:0] HOLD_LOAD = ecs_pkg::HOLD_W'(ecs_pkg::HOLD_CYC);
   localparam logic [ecs_pkg::HOLD_W-1:0] HOLD_ONE  = ecs_pkg::HOLD_W'(1);
   localparam logic [ecs_pkg::HOLD_W-1:0] HOLD_ZERO = '0;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_q, rst_n_q;

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // pin filtering and bus events
   // ----------------------------------------------------------------
   ecs_pkg::ecs_pins_type pins_raw, pins;
   ecs_pkg::ecs_evt_type  evt;
   logic                  scl_prev_q, sda_prev_q;

   assign pins_raw.addr = {I_ADDR_PIN_BIT2, I_ADDR_PIN_BIT1, I_ADDR_PIN_BIT0};
   assign pins_raw.sda  = I_SDA_I;
   assign pins_raw.scl  = I_SCL_I;

   ecs_glitch_filter #(
      .W    ($bits(ecs_pkg::ecs_pins_type)),
      .FILT (ecs_pkg::SPIKE_CYC)
   ) u_filter (
      .i_clk   (I_SYS_CLK),
      .i_rst_n (rst_n_q),
      .i_raw   (pins_raw),
      .o_clean (pins)                                    // [R11]
   );

   always_ff @(posedge I_SYS_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= pins.scl;
         sda_prev_q <= pins.sda;
      end
   end

   always_comb begin
      evt.scl_rise = pins.scl & ~scl_prev_q;
      evt.scl_fall = ~pins.scl & scl_prev_q;
      evt.start    = pins.scl & scl_prev_q & sda_prev_q & ~pins.sda;
      evt.stop     = pins.scl & scl_prev_q & ~sda_prev_q & pins.sda;
   end

   // ----------------------------------------------------------------
   // serial state machine
   // ----------------------------------------------------------------
   ecs_pkg::ecs_state_type state_q, state_d;
   logic [3:0]                    bit_q, bit_d;
   logic [7:0]                    shift_q, shift_d;
   logic [7:0]                    pend_q, pend_d;
   logic [7:0]                    ctrl_q, ctrl_d;
   logic                          pend_v_q, pend_v_d;
   logic                          rw_q, rw_d;
   logic                          ack_ok_q, ack_ok_d;
   logic                          low_tgt_q, low_tgt_d;
   logic                          drive_q, drive_d;
   logic [ecs_pkg::HOLD_W-1:0]    hold_q, hold_d;
   logic                          addr_hit;

   assign addr_hit = (shift_q[7:1] == {ecs_pkg::ADDR_HI, pins.addr});                 // [R4] [R13]

   always_comb begin
      state_d   = state_q;
      bit_d     = bit_q;
      shift_d   = shift_q;
      pend_d    = pend_q;
      ctrl_d    = ctrl_q;
      pend_v_d  = pend_v_q;
      rw_d      = rw_q;
      ack_ok_d  = ack_ok_q;
      low_tgt_d = low_tgt_q;
      drive_d   = drive_q;
      hold_d    = HOLD_ZERO;
      // output changes after the hold window past a clock fall, or at once on start or stop
      if (hold_q != HOLD_ZERO) begin
         hold_d = hold_q - HOLD_ONE;
         if (hold_q == HOLD_ONE) begin
            drive_d = low_tgt_q;                         // [R12]
         end
      end
      if (evt.start) begin
         state_d   = ecs_pkg::ST_ADDR;
         bit_d     = ecs_pkg::BIT_ZERO;
         low_tgt_d = 1'b0;
         drive_d   = 1'b0;
         hold_d    = HOLD_ZERO;
      end else if (evt.stop) begin
         if (pend_v_q) begin
            ctrl_d = pend_q;                             // [R15]
         end
         pend_v_d  = 1'b0;
         state_d   = ecs_pkg::ST_IDLE;
         low_tgt_d = 1'b0;
         drive_d   = 1'b0;
         hold_d    = HOLD_ZERO;
      end else begin
         if (evt.scl_fall) begin
            hold_d = HOLD_LOAD;
         end
         unique case (state_q)
            ecs_pkg::ST_IDLE: begin
               hold_d = HOLD_ZERO;
            end
            ecs_pkg::ST_ADDR: begin
               if (evt.scl_rise) begin
                  shift_d = {shift_q[6:0], pins.sda};
                  bit_d   = bit_q + ecs_pkg::BIT_ONE;
               end else if (evt.scl_fall && bit_q == ecs_pkg::BYTE_BITS) begin
                  if (addr_hit) begin
                     state_d   = ecs_pkg::ST_ADDR_ACK;
                     rw_d      = shift_q[0];                        // [R14]
                     low_tgt_d = 1'b1;                              // [R3]
                  end else begin
                     state_d = ecs_pkg::ST_IDLE;
                  end
               end
            end
            ecs_pkg::ST_ADDR_ACK: begin
               if (evt.scl_fall) begin
                  bit_d = ecs_pkg::BIT_ZERO;
                  if (rw_q) begin
                     state_d   = ecs_pkg::ST_RD_DATA;
                     shift_d   = ctrl_q;                            // [R16]
                     low_tgt_d = ~ctrl_q[7];
                  end else begin
                     state_d   = ecs_pkg::ST_WR_DATA;
                     low_tgt_d = 1'b0;
                  end
               end
            end
            ecs_pkg::ST_WR_DATA: begin
               if (evt.scl_rise) begin
                  shift_d = {shift_q[6:0], pins.sda};
                  bit_d   = bit_q + ecs_pkg::BIT_ONE;
               end else if (evt.scl_fall && bit_q == ecs_pkg::BYTE_BITS) begin
                  state_d   = ecs_pkg::ST_WR_ACK;
                  pend_d    = shift_q;                              // [R3] [R15]
                  pend_v_d  = 1'b1;
                  low_tgt_d = 1'b1;
               end
            end
            ecs_pkg::ST_WR_ACK: begin
               if (evt.scl_fall) begin
                  state_d   = ecs_pkg::ST_WR_DATA;
                  bit_d     = ecs_pkg::BIT_ZERO;
                  low_tgt_d = 1'b0;
               end
            end
            ecs_pkg::ST_RD_DATA: begin
               if (evt.scl_fall) begin
                  if (bit_q == ecs_pkg::LAST_BIT) begin
                     state_d   = ecs_pkg::ST_RD_ACK;
                     low_tgt_d = 1'b0;
                  end else begin
                     bit_d     = bit_q + ecs_pkg::BIT_ONE;
                     shift_d   = {shift_q[6:0], 1'b0};
                     low_tgt_d = ~shift_q[6];                       // [R16]
                  end
               end
            end
            ecs_pkg::ST_RD_ACK: begin
               if (evt.scl_rise) begin
                  ack_ok_d = ~pins.sda;
               end else if (evt.scl_fall) begin
                  bit_d = ecs_pkg::BIT_ZERO;
                  if (ack_ok_q) begin
                     state_d   = ecs_pkg::ST_RD_DATA;
                     shift_d   = ctrl_q;
                     low_tgt_d = ~ctrl_q[7];
                  end else begin
                     state_d   = ecs_pkg::ST_IDLE;
                     low_tgt_d = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q   <= ecs_pkg::ST_IDLE;                  // [R5]
         bit_q     <= ecs_pkg::BIT_ZERO;
         shift_q   <= ecs_pkg::CTRL_RST;
         pend_q    <= ecs_pkg::CTRL_RST;
         ctrl_q    <= ecs_pkg::CTRL_RST;                 // [R6]
         pend_v_q  <= 1'b0;
         rw_q      <= 1'b0;
         ack_ok_q  <= 1'b0;
         low_tgt_q <= 1'b0;
         drive_q   <= 1'b0;
         hold_q    <= '0;
      end else begin
         state_q   <= state_d;
         bit_q     <= bit_d;
         shift_q   <= shift_d;
         pend_q    <= pend_d;
         ctrl_q    <= ctrl_d;
         pend_v_q  <= pend_v_d;
         rw_q      <= rw_d;
         ack_ok_q  <= ack_ok_d;
         low_tgt_q <= low_tgt_d;
         drive_q   <= drive_d;
         hold_q    <= hold_d;
      end
   end

   // ----------------------------------------------------------------
   // enable word handshake to the link side
   // ----------------------------------------------------------------
   logic [7:0] sent_q, sent_d;
   logic       req_q, req_d, busy_q, busy_d;
   logic       ack_tgl, ack_meta_q, ack_s_q, ack_prev_q;

   always_comb begin
      sent_d = sent_q;
      req_d  = req_q;
      busy_d = busy_q;
      if (busy_q && (ack_s_q != ack_prev_q)) begin
         busy_d = 1'b0;
      end else if (!busy_q && (ctrl_q != sent_q)) begin
         sent_d = ctrl_q;
         req_d  = ~req_q;
         busy_d = 1'b1;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sent_q     <= ecs_pkg::CTRL_RST;
         req_q      <= 1'b0;
         busy_q     <= 1'b0;
         ack_meta_q <= 1'b0;
         ack_s_q    <= 1'b0;
         ack_prev_q <= 1'b0;
      end else begin
         sent_q     <= sent_d;
         req_q      <= req_d;
         busy_q     <= busy_d;
         ack_meta_q <= ack_tgl;
         ack_s_q    <= ack_meta_q;
         ack_prev_q <= ack_s_q;
      end
   end

   // ----------------------------------------------------------------
   // link side instance
   // ----------------------------------------------------------------
   logic up_scl_pl, up_sda_pl;

   ecs_link_switch #(
      .N (ecs_pkg::NUM_CHAN)
   ) u_link (
      .i_link_clk  (I_LINK_CLK),
      .i_rst_n     (I_RST_N),
      .i_req_tgl   (req_q),
      .i_en_word   (sent_q),
      .o_ack_tgl   (ack_tgl),
      .i_up_scl    (I_SCL_I),
      .i_up_sda    (I_SDA_I),
      .i_dn_scl    (I_DOWNSTREAM_CLOCK_LINE_I),
      .i_dn_sda    (I_DOWNSTREAM_DATA_LINE_I),
      .o_dn_scl_oe (O_DOWNSTREAM_CLOCK_LINE_OE),
      .o_dn_sda_oe (O_DOWNSTREAM_DATA_LINE_OE),
      .o_up_scl_pl (up_scl_pl),
      .o_up_sda_pl (up_sda_pl),
      .o_chan_en   (O_CHAN_EN)
   );

   // ----------------------------------------------------------------
   // upstream open-drain outputs
   // ----------------------------------------------------------------
   logic pl_meta_scl_q, pl_s_scl_q, pl_meta_sda_q, pl_s_sda_q;
   logic scl_oe_q, sda_oe_q;

   // async reset drops the data pull at once, well inside the limit
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         pl_meta_scl_q <= 1'b0;
         pl_s_scl_q    <= 1'b0;
         pl_meta_sda_q <= 1'b0;
         pl_s_sda_q    <= 1'b0;
         scl_oe_q      <= 1'b0;
         sda_oe_q      <= 1'b0;                          // [R9]
      end else begin
         pl_meta_scl_q <= up_scl_pl;
         pl_s_scl_q    <= pl_meta_scl_q;
         pl_meta_sda_q <= up_sda_pl;
         pl_s_sda_q    <= pl_meta_sda_q;
         scl_oe_q      <= pl_s_scl_q;
         sda_oe_q      <= drive_q | pl_s_sda_q;
      end
   end

   assign O_SCL_OE                  = scl_oe_q;
   assign O_SDA_OE                  = sda_oe_q;
   assign O_SCL_O                   = 1'b0;
   assign O_SDA_O                   = 1'b0;
   assign O_DOWNSTREAM_CLOCK_LINE_O = '0;
   assign O_DOWNSTREAM_DATA_LINE_O  = '0;

endmodule : ecs_switch_top

// ==== test/ecs_checker.sv ====
// port assertions for the switch control top
// assumes bind onto ecs_switch_top; wires resolved by the bench
`timescale 1ns/1ps
module ecs_checker (
   input wire logic       I_SYS_CLK, I_LINK_CLK, I_RST_N,    // clocks, reset
   input wire logic       I_SCL_I, I_SDA_I, O_SCL_OE, O_SDA_OE, // upstream
   input wire logic [7:0] O_DOWNSTREAM_CLOCK_LINE_OE,          // channel clocks
   input wire logic [7:0] O_DOWNSTREAM_DATA_LINE_OE,           // channel data
   input wire logic [7:0] O_CHAN_EN                            // enables
);
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RST_N);
   chk_rst_clears: assert property ($rose(I_RST_N) |-> O_CHAN_EN == 8'h00 && !O_SDA_OE)
      else $error("reset left state behind");
   chk_sda_hold: assert property ($fell(I_SCL_I) |=> $stable(O_SDA_OE) [*8])
      else $error("data changed too soon after clock fall");
   chk_sda_steady: assert property (I_SCL_I && $past(I_SCL_I) && $stable(I_SDA_I) |-> $stable(O_SDA_OE))
      else $error("data drive changed while clock high");
   chk_stop_quiet: assert property ($rose(I_SDA_I) && I_SCL_I |=> !O_SDA_OE [*8])
      else $error("data pulled after stop");
   chk_chan_gate: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
      $stable(O_CHAN_EN) [*3] |-> ((O_DOWNSTREAM_CLOCK_LINE_OE | O_DOWNSTREAM_DATA_LINE_OE) & ~O_CHAN_EN) == 8'h00)
      else $error("disabled channel driven");
   chk_apply_stop: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
      !$stable(O_CHAN_EN) |-> I_SCL_I && I_SDA_I) else $error("enables changed outside idle bus");
   chk_idle_pull: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
      O_CHAN_EN == 8'h00 [*4] |-> !O_SCL_OE) else $error("clock pulled with no channel");
   chk_dn_follow: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
      (!I_SCL_I && $stable(O_CHAN_EN)) [*5] |-> O_DOWNSTREAM_CLOCK_LINE_OE == O_CHAN_EN)
      else $error("clock low not passed to enabled channels");
   cov_en_low: cover property (O_CHAN_EN != 8'h00 && !I_SCL_I);
   cov_drive: cover property ($rose(O_SDA_OE));
   cov_mask: cover property (O_CHAN_EN == 8'h7F);
endmodule : ecs_checker

// ==== test/ecs_master.sv ====
// upstream bus master model: conditions and bytes
// assumes pull-ups on both wires resolved by the bench
`timescale 1ns/1ps
module ecs_master (
   input  wire logic clk,    // time base
   input  wire logic sda,    // resolved data wire
   output logic      scl_pl, // pull clock low
   output logic      sda_pl  // pull data low
);
   logic glitch = 1'b0;
   initial {scl_pl, sda_pl} = 2'h0;
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : w
   // clock low 1.5 us, high 1 us
   task automatic bit_x(input logic b, output logic r);
      w(50);
      sda_pl = !b;
      w(100);
      scl_pl = 1'b0;
      w(50);
      r = sda;
      sda_pl = sda_pl ^ glitch; // 30 ns spike on request
      w(3);
      sda_pl = !b;
      w(47);
      scl_pl = 1'b1;
   endtask : bit_x
   task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic nk);
      for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
      bit_x(1'b1, nk);
   endtask : xfer
   // start when stp is 0, stop and bus free when 1
   task automatic cond(input logic stp);
      w(50);
      sda_pl = 1'b1;
      w(100);
      scl_pl = 1'b0;
      w(60);
      sda_pl = !stp;
      w(60);
      scl_pl = !stp;
      w(70);
   endtask : cond
endmodule : ecs_master

// ==== test/ecs_switch_top_tb.sv ====
// bench of the switch control: writes, reads, faults, reset
// assumes ecs_master model; checker bound at the foot
`timescale 1ns/1ps
module ecs_switch_top_tb;
   logic       sys_clk, link_clk, rst_n, m_scl, m_sda, nk, up_scl_oe, up_sda_oe;
   logic [2:0] ap;
   logic [7:0] v, r, dpl, chan_en, dn_scl_oe, dn_sda_oe, q[$], oq[$];
   wire        scl = !(m_scl | up_scl_oe);
   wire        sda = !(m_sda | up_sda_oe);
   int         errors, n_tests, seed;
   event       seen;
   ecs_master m (.clk(sys_clk), .sda(sda), .scl_pl(m_scl), .sda_pl(m_sda));
   ecs_switch_top dut (.I_SYS_CLK(sys_clk), .I_RST_N(rst_n), .I_LINK_CLK(link_clk), .I_SCL_I(scl),
      .O_SCL_O(), .O_SCL_OE(up_scl_oe), .I_SDA_I(sda), .O_SDA_O(), .O_SDA_OE(up_sda_oe),
      .I_ADDR_PIN_BIT0(ap[0]), .I_ADDR_PIN_BIT1(ap[1]), .I_ADDR_PIN_BIT2(ap[2]),
      .I_DOWNSTREAM_CLOCK_LINE_I(~dn_scl_oe), .O_DOWNSTREAM_CLOCK_LINE_O(), .O_DOWNSTREAM_CLOCK_LINE_OE(dn_scl_oe),
      .I_DOWNSTREAM_DATA_LINE_I(~(dn_sda_oe | dpl)), .O_DOWNSTREAM_DATA_LINE_O(), .O_DOWNSTREAM_DATA_LINE_OE(dn_sda_oe),
      .O_CHAN_EN(chan_en));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #80 link_clk = ~link_clk;
   end
   task automatic report_and_stop();
      if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task automatic cmp(input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp
   task automatic note(input logic [7:0] e, input logic [7:0] o);
      q.push_back(e);
      oq.push_back(o);
      -> seen;
   endtask : note
   always @(seen) while (q.size() > 0) cmp(q.pop_front(), oq.pop_front());
   task automatic txn(input logic [6:0] a, input logic rd, input logic [7:0] d, input logic nak);
      m.cond(1'b0);
      m.xfer({a, rd}, r, nk);
      note({7'h00, nak}, {7'h00, nk});
      if (!nak) begin
         m.xfer(rd ? 8'hFF : d, r, nk);
         note(rd ? d : 8'h00, rd ? r : {7'h00, nk});
      end
      m.cond(1'b1);
   endtask : txn
   initial begin
      {rst_n, ap, v, dpl} = '0;
      {errors, n_tests, seed} = {32'd0, 32'd0, 32'd23};
      repeat (2) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 8; i++) begin
         ap = i[2:0];
         v = 8'($random(seed));
         m.w(20);
         txn({4'hE, ap}, 1'b0, v, 1'b0);
         m.w(150);
         note(v, chan_en);
         if (i[0]) txn({4'hE, ap}, 1'b1, v, 1'b0);
      end
      txn(7'h70, 1'b0, 8'h00, 1'b1);
      m.glitch = 1'b1;
      m.cond(1'b0);
      m.xfer({4'hE, ap, 1'b0}, r, nk);
      m.xfer(8'hA5, r, nk);
      m.xfer(8'h7F, r, nk);
      note(8'h00, {7'h00, nk});
      m.w(150);
      note(v, chan_en);
      m.cond(1'b1);
      m.glitch = 1'b0;
      m.w(150);
      note(8'h7F, chan_en);
      dpl = 8'h01 << ({$random(seed)} % 7);
      m.w(100);
      note(8'h00, {7'h00, sda});
      dpl = 8'h00;
      m.w(100);
      note(8'h01, {7'h00, sda});
      m.cond(1'b0);
      m.xfer(8'hE1 | {4'h0, ap, 1'b0}, r, nk);
      m.w(100);
      note(8'h00, {7'h00, sda});
      rst_n = 1'b0;
      m.w(50);
      note(8'h01, {7'h00, sda});
      note(8'h00, chan_en);
      m.w(15);
      rst_n = 1'b1; // held well past the minimum
      m.cond(1'b1);
      txn({4'hE, ap}, 1'b1, 8'h00, 1'b0);
      report_and_stop();
   end
   initial begin
      #1000000;
      errors++;
      report_and_stop();
   end
endmodule : ecs_switch_top_tb
bind ecs_switch_top ecs_checker chk (.*);
